// *** logic/fil_defines.svh ***
`ifndef FIL_DEFINES_SVH
`define FIL_DEFINES_SVH

// register indices; byte address is four times the index
`define FIL_IDX_MASK5 10'h033
`define FIL_IDX_LTCH0 10'h034
`define FIL_IDX_CHSUM 10'h035
`define FIL_IDX_OUT1 10'h038
`define FIL_IDX_OUT2 10'h039
`define FIL_IDX_LIVE0 10'h03c
`define FIL_IDX_IRQ_STAT 10'h050
`define FIL_IDX_IRQ_MASK 10'h051

// reset values
`define FIL_RST_MASK5 8'h30
`define FIL_RST_LTCH0 8'h00
`define FIL_RST_CHSUM 8'h00
`define FIL_RST_OUT1 8'h00
`define FIL_RST_OUT2 8'h00
`define FIL_RST_IRQ_STAT 8'h00
`define FIL_RST_IRQ_MASK 8'h00

// threshold / voice mask bit positions
`define FIL_M5_GPA_UP 7
`define FIL_M5_GPA_LOW 6
`define FIL_M5_VAD_UP 5
`define FIL_M5_VAD_DOWN 4

// clock / lock latch positions (also live register)
`define FIL_L0_CLK_ERR 7
`define FIL_L0_PLL_LOCK 6

// channel summary positions
`define FIL_CS_IN1 7
`define FIL_CS_IN2 6
`define FIL_CS_OUT1 5
`define FIL_CS_OUT2 4

// output fault register positions
`define FIL_OF_SC_POS 7
`define FIL_OF_SC_NEG 6
`define FIL_OF_VG_POS 5
`define FIL_OF_VG_NEG 4
`define FIL_O1_ADC1_MASK 3
`define FIL_O1_ADC2_MASK 2
`define FIL_O2_REG_MASK 1
`define FIL_O2_REG_SHORT 0

// interrupt status / mask positions
`define FIL_IS_CLK_ERR 7
`define FIL_IS_PLL_LOCK 6
`define FIL_IS_GPA_UP 5
`define FIL_IS_GPA_LOW 4
`define FIL_IS_VAD_UP 3
`define FIL_IS_VAD_DOWN 2
`define FIL_IS_OUT_FAULT 1
`define FIL_IS_REG_SHORT 0

// width of the synchronised source vector: 19 fault inputs plus two zero bits
`define FIL_NUM_SRC 21

`endif

// *** logic/fil_pkg.sv ***
`default_nettype none

package fil_pkg;

    // one register byte
    typedef logic [7:0] fil_byte_type;

    // word index into the register map
    typedef logic [9:0] fil_index_type;

    // apb byte address
    typedef logic [11:0] fil_addr_type;

endpackage : fil_pkg

`default_nettype wire

// *** logic/fil_fault_irq_latch.sv ***
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`include "fil_defines.svh"
`default_nettype none

module fil_fault_irq_latch (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire fil_pkg::fil_addr_type paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // clock and lock conditions
    input wire logic clock_error,
    input wire logic pll_lock_event,
    // general analog input thresholds
    input wire logic general_analog_input_upper,
    input wire logic general_analog_input_lower,
    // voice activity detector
    input wire logic voice_activity_detector_up,
    input wire logic voice_activity_detector_down,
    // input channel fault summaries
    input wire logic input_one_fault,
    input wire logic input_two_fault,
    input wire logic adc_one_overload,
    input wire logic adc_two_overload,
    // output channel one faults
    input wire logic output_one_positive_pin_short,
    input wire logic output_one_negative_pin_short,
    input wire logic output_one_driver_positive_side_vg,
    input wire logic output_one_driver_negative_side_vg,
    // output channel two faults
    input wire logic output_two_positive_pin_short,
    input wire logic output_two_negative_pin_short,
    input wire logic output_two_driver_positive_side_vg,
    input wire logic output_two_driver_negative_side_vg,
    // analog regulator
    input wire logic regulator_short,
    // interrupt
    output logic irq
);
    import fil_pkg::*;

    localparam int NSRC = `FIL_NUM_SRC;

    // word index of an aligned apb address
    function automatic fil_index_type addr_index(input fil_addr_type a);
        addr_index = a[11:2];
    endfunction : addr_index

    // true when an aligned address selects the given register
    function automatic logic hits(input fil_addr_type a, input fil_index_type idx);
        hits = (a[1:0] == 2'h0) && (addr_index(a) == idx);
    endfunction : hits

    // raw source vector, ordered as the synchroniser holds it
    logic [NSRC-1:0] src_raw;
    logic [NSRC-1:0] sync1_reg;
    logic [NSRC-1:0] sync2_reg;
    logic [NSRC-1:0] prev_reg;

    // register state
    fil_byte_type mask5_reg;
    fil_byte_type ltch0_reg;
    fil_byte_type chsum_reg;
    fil_byte_type out1_reg;
    fil_byte_type out2_reg;
    fil_byte_type irq_stat_reg;
    fil_byte_type irq_mask_reg;
    fil_byte_type ltch0_next;
    fil_byte_type chsum_next;
    fil_byte_type out1_next;
    fil_byte_type out2_next;
    fil_byte_type irq_stat_next;
    fil_byte_type live0;
    fil_byte_type rd_byte;

    // bus phase decode
    logic setup_phase;
    logic access_rd;
    logic access_wr;
    logic mapped;
    logic [7:0] wr_byte;
    logic wr_lane0;

    // synchronised condition names
    logic s_clk_err;
    logic s_pll;
    logic s_gpa_up;
    logic s_gpa_low;
    logic s_vad_up;
    logic s_vad_dn;
    logic s_in1;
    logic s_in2;
    logic s_adc1;
    logic s_adc2;
    logic [3:0] s_out1;
    logic [3:0] s_out2;
    logic s_reg;

    // rising edges for the sticky interrupt status
    logic [NSRC-1:0] rise;

    // gather the analog detector outputs
    assign src_raw = {
        clock_error,
        pll_lock_event,
        general_analog_input_upper,
        general_analog_input_lower,
        voice_activity_detector_up,
        voice_activity_detector_down,
        input_one_fault,
        input_two_fault,
        adc_one_overload,
        adc_two_overload,
        output_one_positive_pin_short,
        output_one_negative_pin_short,
        output_one_driver_positive_side_vg,
        output_one_driver_negative_side_vg,
        output_two_positive_pin_short,
        output_two_negative_pin_short,
        output_two_driver_positive_side_vg,
        output_two_driver_negative_side_vg,
        regulator_short,
        2'h0
    };

    // two-flop synchroniser; detectors run off other clocks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= src_raw;
            sync2_reg <= sync1_reg;
        end
    end

    // previous synchronised level, for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_reg <= '0;
        end else begin
            prev_reg <= sync2_reg;
        end
    end

    assign rise = sync2_reg & ~prev_reg;

    // name the synchronised levels
    assign s_clk_err = sync2_reg[20];
    assign s_pll = sync2_reg[19];
    assign s_gpa_up = sync2_reg[18];
    assign s_gpa_low = sync2_reg[17];
    assign s_vad_up = sync2_reg[16];
    assign s_vad_dn = sync2_reg[15];
    assign s_in1 = sync2_reg[14];
    assign s_in2 = sync2_reg[13];
    assign s_adc1 = sync2_reg[12];
    assign s_adc2 = sync2_reg[11];
    assign s_out1 = sync2_reg[10:7];
    assign s_out2 = sync2_reg[6:3];
    assign s_reg = sync2_reg[2];

    // apb phases; zero wait states, read data captured in setup, writes land in access
    assign setup_phase = psel && !penable;
    assign access_rd = psel && penable && !pwrite;
    assign access_wr = psel && penable && pwrite;
    assign wr_byte = pwdata[7:0];
    assign wr_lane0 = pstrb[0];

    // every access completes on its first access cycle
    assign pready = psel && penable;

    // address decode
    always_comb begin
        mapped = hits(paddr, `FIL_IDX_MASK5)
            || hits(paddr, `FIL_IDX_LTCH0)
            || hits(paddr, `FIL_IDX_CHSUM)
            || hits(paddr, `FIL_IDX_OUT1)
            || hits(paddr, `FIL_IDX_OUT2)
            || hits(paddr, `FIL_IDX_LIVE0)
            || hits(paddr, `FIL_IDX_IRQ_STAT)
            || hits(paddr, `FIL_IDX_IRQ_MASK);
    end

    // live copy, not latched
    always_comb begin
        live0 = 8'h00;
        live0[`FIL_L0_CLK_ERR] = s_clk_err;
        live0[`FIL_L0_PLL_LOCK] = s_pll;
    end

    // read mux
    always_comb begin
        rd_byte = 8'h00;
        if (hits(paddr, `FIL_IDX_MASK5)) begin
            rd_byte = mask5_reg;
        end else if (hits(paddr, `FIL_IDX_LTCH0)) begin
            rd_byte = ltch0_reg;
        end else if (hits(paddr, `FIL_IDX_CHSUM)) begin
            rd_byte = chsum_reg;
        end else if (hits(paddr, `FIL_IDX_OUT1)) begin
            rd_byte = out1_reg;
        end else if (hits(paddr, `FIL_IDX_OUT2)) begin
            rd_byte = out2_reg;
        end else if (hits(paddr, `FIL_IDX_LIVE0)) begin
            rd_byte = live0;
        end else if (hits(paddr, `FIL_IDX_IRQ_STAT)) begin
            rd_byte = irq_stat_reg;
        end else if (hits(paddr, `FIL_IDX_IRQ_MASK)) begin
            rd_byte = irq_mask_reg;
        end
    end

    // read data and error captured at setup, held through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            prdata <= {24'h00_0000, rd_byte};
            pslverr <= !mapped;
        end
    end

    // threshold and voice mask; all bits stored as written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask5_reg <= `FIL_RST_MASK5;
        end else if (access_wr && wr_lane0 && hits(paddr, `FIL_IDX_MASK5)) begin
            mask5_reg <= wr_byte;
        end
    end

    // clock / lock latch: condition sets, read clears unless still present
    always_comb begin
        ltch0_next = ltch0_reg;
        if (access_rd && hits(paddr, `FIL_IDX_LTCH0)) begin
            ltch0_next = 8'h00;
        end
        // set wins over the read clear
        ltch0_next[`FIL_L0_CLK_ERR] = ltch0_next[`FIL_L0_CLK_ERR] | s_clk_err;
        ltch0_next[`FIL_L0_PLL_LOCK] = ltch0_next[`FIL_L0_PLL_LOCK] | s_pll;
        ltch0_next[5:0] = 6'h00;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ltch0_reg <= `FIL_RST_LTCH0;
        end else begin
            ltch0_reg <= ltch0_next;
        end
    end

    // channel summary latch; overloads count unless masked
    always_comb begin
        chsum_next = chsum_reg;
        if (access_rd && hits(paddr, `FIL_IDX_CHSUM)) begin
            chsum_next = 8'h00;
        end
        chsum_next[`FIL_CS_IN1] = chsum_next[`FIL_CS_IN1] | s_in1
            | (s_adc1 & ~out1_reg[`FIL_O1_ADC1_MASK]);
        chsum_next[`FIL_CS_IN2] = chsum_next[`FIL_CS_IN2] | s_in2
            | (s_adc2 & ~out1_reg[`FIL_O1_ADC2_MASK]);
        chsum_next[`FIL_CS_OUT1] = chsum_next[`FIL_CS_OUT1] | (|s_out1);
        chsum_next[`FIL_CS_OUT2] = chsum_next[`FIL_CS_OUT2] | (|s_out2);
        chsum_next[3:0] = 4'h0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chsum_reg <= `FIL_RST_CHSUM;
        end else begin
            chsum_reg <= chsum_next;
        end
    end

    // output one: latched fault nibble plus two writable masks
    always_comb begin
        out1_next = out1_reg;
        if (access_rd && hits(paddr, `FIL_IDX_OUT1)) begin
            out1_next[7:4] = 4'h0;
        end
        out1_next[7:4] = out1_next[7:4] | s_out1;
        if (access_wr && wr_lane0 && hits(paddr, `FIL_IDX_OUT1)) begin
            out1_next[3:2] = wr_byte[3:2];
        end
        out1_next[1:0] = 2'h0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out1_reg <= `FIL_RST_OUT1;
        end else begin
            out1_reg <= out1_next;
        end
    end

    // output two: latched fault nibble, regulator mask and latch
    always_comb begin
        out2_next = out2_reg;
        if (access_rd && hits(paddr, `FIL_IDX_OUT2)) begin
            out2_next[7:4] = 4'h0;
            out2_next[`FIL_O2_REG_SHORT] = 1'b0;
        end
        out2_next[7:4] = out2_next[7:4] | s_out2;
        // a masked regulator short is neither latched nor signalled
        out2_next[`FIL_O2_REG_SHORT] = out2_next[`FIL_O2_REG_SHORT]
            | (s_reg & ~out2_reg[`FIL_O2_REG_MASK]);
        if (access_wr && wr_lane0 && hits(paddr, `FIL_IDX_OUT2)) begin
            out2_next[`FIL_O2_REG_MASK] = wr_byte[`FIL_O2_REG_MASK];
        end
        out2_next[3:2] = 2'h0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out2_reg <= `FIL_RST_OUT2;
        end else begin
            out2_reg <= out2_next;
        end
    end

    // sticky interrupt status: rising edges set, write one clears, set wins
    always_comb begin
        irq_stat_next = irq_stat_reg;
        if (access_wr && wr_lane0 && hits(paddr, `FIL_IDX_IRQ_STAT)) begin
            irq_stat_next = irq_stat_reg & ~wr_byte;
        end
        irq_stat_next[`FIL_IS_CLK_ERR] = irq_stat_next[`FIL_IS_CLK_ERR] | rise[20];
        irq_stat_next[`FIL_IS_PLL_LOCK] = irq_stat_next[`FIL_IS_PLL_LOCK] | rise[19];
        irq_stat_next[`FIL_IS_GPA_UP] = irq_stat_next[`FIL_IS_GPA_UP]
            | (rise[18] & ~mask5_reg[`FIL_M5_GPA_UP]);
        irq_stat_next[`FIL_IS_GPA_LOW] = irq_stat_next[`FIL_IS_GPA_LOW]
            | (rise[17] & ~mask5_reg[`FIL_M5_GPA_LOW]);
        irq_stat_next[`FIL_IS_VAD_UP] = irq_stat_next[`FIL_IS_VAD_UP]
            | (rise[16] & ~mask5_reg[`FIL_M5_VAD_UP]);
        irq_stat_next[`FIL_IS_VAD_DOWN] = irq_stat_next[`FIL_IS_VAD_DOWN]
            | (rise[15] & ~mask5_reg[`FIL_M5_VAD_DOWN]);
        irq_stat_next[`FIL_IS_OUT_FAULT] = irq_stat_next[`FIL_IS_OUT_FAULT] | (|rise[10:3]);
        irq_stat_next[`FIL_IS_REG_SHORT] = irq_stat_next[`FIL_IS_REG_SHORT]
            | (rise[2] & ~out2_reg[`FIL_O2_REG_MASK]);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_reg <= `FIL_RST_IRQ_STAT;
        end else begin
            irq_stat_reg <= irq_stat_next;
        end
    end

    // interrupt enable mask, one = blocked
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_reg <= `FIL_RST_IRQ_MASK;
        end else if (access_wr && wr_lane0 && hits(paddr, `FIL_IDX_IRQ_MASK)) begin
            irq_mask_reg <= wr_byte;
        end
    end

    // level interrupt; combinational from registers only
    assign irq = |(irq_stat_reg & ~irq_mask_reg);

endmodule : fil_fault_irq_latch

`default_nettype wire

// *** tb/fil_fault_irq_latch_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none

module fil_fault_irq_latch_asserts (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire fil_pkg::fil_addr_type paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // watched source and interrupt
    input wire logic clock_error,
    input wire logic irq
);
    import fil_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic rd_setup;
    logic wr_acc;
    fil_byte_type mask5_shadow;
    assign rd_setup = psel && !penable && !pwrite;
    assign wr_acc = psel && penable && pwrite && pstrb[0];
    // shadow of the threshold and voice mask; a refused strobe must not move it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask5_shadow <= 8'h30;
        end else if (wr_acc && paddr == 12'h0cc) begin
            mask5_shadow <= pwdata[7:0];
        end
    end
    chk_ready_access: assert property ((psel && !penable) ##1 penable |-> pready)
        else $error("no ready in access cycle");
    chk_bad_addr: assert property (psel && !penable && paddr[1:0] != 2'h0
        |=> pslverr && prdata == 32'h0) else $error("misaligned access not refused");
    chk_mask_rw: assert property (
        rd_setup && paddr == 12'h0cc |=> prdata[7:0] == mask5_shadow)
        else $error("mask register readback wrong");
    chk_latch_rsvd: assert property (
        rd_setup && paddr == 12'h0d0 |=> prdata[5:0] == 6'h00)
        else $error("clock latch low bits not zero");
    chk_summary_rsvd: assert property (
        rd_setup && paddr == 12'h0d4 |=> prdata[3:0] == 4'h0)
        else $error("summary low bits not zero");
    chk_out1_rsvd: assert property (
        rd_setup && paddr == 12'h0e0 |=> prdata[1:0] == 2'h0)
        else $error("output one low bits not zero");
    chk_out2_rsvd: assert property (
        rd_setup && paddr == 12'h0e4 |=> prdata[3:2] == 2'h0)
        else $error("output two reserved bits not zero");
    chk_live_clock: assert property (
        clock_error [*4] ##0 (rd_setup && paddr == 12'h0f0) |=> prdata[7])
        else $error("live clock error not shown");
    chk_irq_reset: assert property ($rose(presetn) |-> !irq)
        else $error("interrupt high after reset");
    // main scenarios reached
    cover property (rd_setup && paddr == 12'h0d0 ##1 prdata[7]);
    cover property ($rose(irq));
    cover property (pslverr);
endmodule : fil_fault_irq_latch_asserts

bind fil_fault_irq_latch fil_fault_irq_latch_asserts u_chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .clock_error, .irq);

`default_nettype wire

// *** tb/fil_fault_irq_latch_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module fil_fault_irq_latch_tb_top;
    import fil_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    fil_addr_type paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h1;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [18:0] ev = 19'h0;
    int mismatches = 0;
    int n_compared = 0;
    fil_byte_type rd;
    logic err;
    int ri[13] = '{0, 1, 10, 11, 12, 13, 14, 15, 16, 17, 18, 6, 7};
    fil_addr_type ra[13] = '{12'h0d0, 12'h0d0, 12'h0e0, 12'h0e0, 12'h0e0, 12'h0e0, 12'h0e4,
        12'h0e4, 12'h0e4, 12'h0e4, 12'h0e4, 12'h0d4, 12'h0d4};
    fil_byte_type rm[13] = '{8'h80, 8'h40, 8'h80, 8'h40, 8'h20, 8'h10, 8'h80, 8'h40, 8'h20,
        8'h10, 8'h01, 8'h80, 8'h40};
    fil_byte_type mm[8] = '{8'h30, 8'h30, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h40};
    int me[8] = '{4, 5, 4, 5, 2, 3, 2, 3};
    fil_addr_type raddr[8] = '{12'h0cc, 12'h0d0, 12'h0d4, 12'h0e0, 12'h0e4, 12'h0f0, 12'h140,
        12'h144};

    // 125 MHz
    always #4 pclk = ~pclk;

    fil_fault_irq_latch uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .irq,
        .clock_error(ev[0]), .pll_lock_event(ev[1]),
        .general_analog_input_upper(ev[2]), .general_analog_input_lower(ev[3]),
        .voice_activity_detector_up(ev[4]), .voice_activity_detector_down(ev[5]),
        .input_one_fault(ev[6]), .input_two_fault(ev[7]),
        .adc_one_overload(ev[8]), .adc_two_overload(ev[9]),
        .output_one_positive_pin_short(ev[10]), .output_one_negative_pin_short(ev[11]),
        .output_one_driver_positive_side_vg(ev[12]), .output_one_driver_negative_side_vg(ev[13]),
        .output_two_positive_pin_short(ev[14]), .output_two_negative_pin_short(ev[15]),
        .output_two_driver_positive_side_vg(ev[16]), .output_two_driver_negative_side_vg(ev[17]),
        .regulator_short(ev[18]));

    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results

    task automatic chk(input fil_byte_type got, input fil_byte_type exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer; request held until ready is seen at a rising edge
    task automatic bus(input logic w, input fil_addr_type a, input fil_byte_type d,
        input logic [3:0] s);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            chk(8'h00, 8'h01);
            results();
        end
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : bus

    // the write lands at the ready edge; one more edge lets irq settle before a check
    task automatic wr(input fil_addr_type a, input fil_byte_type d);
        bus(1'b1, a, d, 4'h1);
        @(posedge pclk);
    endtask : wr

    task automatic rdc(input fil_addr_type a, input fil_byte_type m, input fil_byte_type e);
        bus(1'b0, a, 8'h00, 4'h1);
        chk(rd & m, e);
    endtask : rdc

    // long enough for the two-stage synchroniser on both edges
    task automatic pulse(input int i);
        ev[i] <= 1'b1;
        repeat (4) @(posedge pclk);
        ev[i] <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask : pulse

    // main sequence
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        foreach (raddr[k]) begin
            rdc(raddr[k], 8'hff, (k == 0) ? 8'h30 : 8'h00);
        end
        chk({7'h0, irq}, 8'h00);
        // refused accesses leave registers alone
        bus(1'b0, 12'h100, 8'h00, 4'h1);
        chk({7'h0, err}, 8'h01);
        wr(12'h0cd, 8'hc0);
        bus(1'b1, 12'h0cc, 8'hc0, 4'he);
        rdc(12'h0cc, 8'hff, 8'h30);
        wr(12'h0d0, 8'hc0);
        rdc(12'h0d0, 8'hff, 8'h00);
        // masked converter overloads never reach the summary
        wr(12'h0e0, 8'h0c);
        pulse(8);
        pulse(9);
        rdc(12'h0d4, 8'hc0, 8'h00);
        wr(12'h0e0, 8'h00);
        foreach (ri[k]) begin
            if (k == 11) begin
                rdc(12'h0d4, 8'h30, 8'h30);
            end
            pulse(ri[k]);
            chk({7'h0, irq}, {7'h0, ri[k] != 6 && ri[k] != 7});
            rdc(ra[k], rm[k], rm[k]);
            if (k < 11) begin
                rdc(ra[k], rm[k], 8'h00);
            end
            wr(12'h140, 8'hff);
            chk({7'h0, irq}, 8'h00);
        end
        pulse(8);
        rdc(12'h0d4, 8'h80, 8'h80);
        foreach (mm[k]) begin
            wr(12'h0cc, mm[k]);
            pulse(me[k]);
            chk({7'h0, irq}, {7'h0, mm[k] == 8'h00});
            wr(12'h140, 8'hff);
        end
        // interrupt mask hides a pending status bit
        wr(12'h144, 8'h80);
        pulse(0);
        chk({7'h0, irq}, 8'h00);
        rdc(12'h140, 8'h80, 8'h80);
        wr(12'h144, 8'h00);
        chk({7'h0, irq}, 8'h01);
        wr(12'h140, 8'h80);
        chk({7'h0, irq}, 8'h00);
        wr(12'h0e4, 8'h02);
        pulse(18);
        rdc(12'h0e4, 8'hff, 8'h02);
        chk({7'h0, irq}, 8'h00);
        // a condition still present survives the clearing read
        ev[0] <= 1'b1;
        repeat (4) @(posedge pclk);
        rdc(12'h0f0, 8'hff, 8'h80);
        rdc(12'h0d0, 8'h80, 8'h80);
        rdc(12'h0d0, 8'h80, 8'h80);
        ev[0] <= 1'b0;
        repeat (6) @(posedge pclk);
        rdc(12'h0f0, 8'hff, 8'h00);
        rdc(12'h0d0, 8'hff, 8'h80);
        rdc(12'h0d0, 8'hff, 8'h00);
        // second reset in mid-run
        pulse(1);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc(12'h0d0, 8'hff, 8'h00);
        rdc(12'h0cc, 8'hff, 8'h30);
        results();
    end
endmodule : fil_fault_irq_latch_tb_top

`default_nettype wire
